// file: design/pru_l1_fsm.sv
// user-side layer 1 state machine for a primary rate interface
// assumes event inputs come from framer logic on clk, no crossing needed
// Operation
// - report to layer 2 by activate/deactivate, to management by activate/error
// - management activate issued when normal frames return in a fault state, not in power-on
// - error parameter 0 to 4 names power, rai, loss, ais, rai with crc
// - power return enters power-on; normal frames in fault give activates, operational
// - each fault event outside power-off gives its error and state, nothing if already in that state
// - layer 2 deactivate only when leaving operational, not loss, not between faults
// - no signal off/on; normal frames op/far/near; rai in lost/alarm
// - double faults resolved by fixed priority, one event taken per cycle
// - 2048 options 2 and 3: rai without continuous crc is network side
// - 2048 options 2 and 3: rai with continuous crc is user side, near fault
// - other 2048 options: rai always gives far fault
// - 1544 option 2: rai with report from exchange is network side
// - 1544 option 2: rai with report from user side of nt is user side
// - 1544 options 1 and 4: rai treated alike for both fault sides
// - without network distinction every rai enters far fault
// - option to ignore crc with rai merges far and near fault
// - transmit timing locked to received line in normal operation
// - crc errors reported back in operational and network-timed fault states
`include "pru_consts.svh"

module pru_l1_fsm (
    input wire logic clk,                    // 40 MHz system clock
    input wire logic srst,                   // synchronous reset, active high
    input wire logic power_loss,             // local power lost, pulse
    input wire logic power_return,           // local power back, pulse
    input wire pru_pkg::pru_rx_s rx,         // received-line events
    input wire pru_pkg::pru_cfg_s cfg,       // configuration
    output pru_pkg::pru_state_e state,       // current layer 1 state
    output logic l2_activate_ind,            // layer 2 activate pulse
    output logic l2_deactivate_ind,          // layer 2 deactivate pulse
    output logic mgmt_activate_ind,          // management activate pulse
    output logic mgmt_error_ind,             // management error pulse
    output logic [2:0] mgmt_error_param,     // error parameter with pulse
    output pru_pkg::pru_tx_e tx_mode,        // kind of signal to send
    output logic tx_timing_from_rx,          // lock tx timing to rx line
    output logic tx_crc_err_report           // send crc error info, pulse
);
    import pru_pkg::*;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------

    // true in the four fault states
    function automatic logic is_fault(input pru_state_e s);
        is_fault = (s == state_far_fault) || (s == state_signal_lost) ||
                   (s == state_alarm_received) || (s == state_near_fault);
    endfunction

    // states where network timing is available
    function automatic logic has_timing(input pru_state_e s);
        has_timing = (s == state_operational) || (s == state_far_fault) ||
                     (s == state_near_fault);
    endfunction

    // signal sent in each state
    function automatic pru_tx_e tx_of(input pru_state_e s);
        case (s)
            state_operational,
            state_far_fault,
            state_near_fault: tx_of = pru_tx_normal;
            state_signal_lost,
            state_alarm_received: tx_of = pru_tx_rai;
            default: tx_of = pru_tx_none;
        endcase
    endfunction

    // user-side fault on rai: only when the network gives the distinction
    function automatic logic rai_near(input pru_rx_s r, input pru_cfg_s c);
        logic opt23;
        opt23 = (c.option == `PRU_OPT_2) || (c.option == `PRU_OPT_3);
        if (c.ignore_crc_rai) begin
            rai_near = 1'b0;
        end else if (!c.rate_1544 && opt23) begin
            rai_near = r.crc_cont;
        end else if (c.rate_1544 && c.option == `PRU_OPT_2) begin
            rai_near = r.prm_user && !r.prm_exch;
        end else begin
            rai_near = 1'b0;
        end
    endfunction

    // pick the single event of this cycle by fixed priority
    function automatic pru_ev_e pick(input logic pl, input logic pr,
                                     input pru_rx_s r, input pru_cfg_s c);
        if (pl) begin
            pick = pru_ev_pwr_loss;
        end else if (pr) begin
            pick = pru_ev_pwr_ret;
        end else if (r.loss) begin
            pick = pru_ev_loss;
        end else if (r.ais) begin
            pick = pru_ev_ais;
        end else if (r.rai && rai_near(r, c)) begin
            pick = pru_ev_rai_crc;
        end else if (r.rai) begin
            pick = pru_ev_rai;
        end else if (r.normal) begin
            pick = pru_ev_normal;
        end else begin
            pick = pru_ev_none;
        end
    endfunction

    // state that a fault event leads to
    function automatic pru_state_e target(input pru_ev_e e);
        case (e)
            pru_ev_loss: target = state_signal_lost;
            pru_ev_ais: target = state_alarm_received;
            pru_ev_rai_crc: target = state_near_fault;
            pru_ev_rai: target = state_far_fault;
            default: target = state_power_off;
        endcase
    endfunction

    // error parameter carried by an event
    function automatic logic [2:0] err_of(input pru_ev_e e);
        case (e)
            pru_ev_rai: err_of = `PRU_ERR_RAI;
            pru_ev_loss: err_of = `PRU_ERR_LOSS;
            pru_ev_ais: err_of = `PRU_ERR_AIS;
            pru_ev_rai_crc: err_of = `PRU_ERR_RAI_CRC;
            default: err_of = `PRU_ERR_POWER;
        endcase
    endfunction

    // ----------------------------------------
    // transition decision
    // ----------------------------------------

    pru_ev_e ev;
    pru_state_e next_state;
    logic next_l2_act;
    logic next_l2_deact;
    logic next_mgmt_act;
    logic next_mgmt_err;
    logic [2:0] next_param;

    // one event per cycle keeps double faults deterministic
    always_comb begin
        ev = pick(power_loss, power_return, rx, cfg);
        next_state = state;
        next_l2_act = 1'b0;
        next_l2_deact = 1'b0;
        next_mgmt_act = 1'b0;
        next_mgmt_err = 1'b0;
        next_param = `PRU_ERR_POWER;
        case (state)
            state_power_off: begin
                if (ev == pru_ev_pwr_ret) begin
                    next_state = state_power_on;
                end
            end
            default: begin
                case (ev)
                    pru_ev_pwr_loss: begin
                        next_state = state_power_off;
                        next_mgmt_err = 1'b1;
                        next_param = `PRU_ERR_POWER;
                        next_l2_deact = (state == state_operational);
                    end
                    pru_ev_loss,
                    pru_ev_ais,
                    pru_ev_rai_crc,
                    pru_ev_rai: begin
                        if (target(ev) != state) begin
                            next_state = target(ev);
                            next_mgmt_err = 1'b1;
                            next_param = err_of(ev);
                            // loss of signal leaves layer 2 untouched
                            next_l2_deact = (state == state_operational) &&
                                            (ev != pru_ev_loss);
                        end
                    end
                    pru_ev_normal: begin
                        if (is_fault(state)) begin
                            next_state = state_operational;
                            next_l2_act = 1'b1;
                            next_mgmt_act = 1'b1;
                        end
                    end
                    default: begin
                        next_state = state;
                    end
                endcase
            end
        endcase
    end

    // ----------------------------------------
    // state and indication registers
    // ----------------------------------------

    // state register, power-off until local power is reported back
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= state_power_off;
        end else begin
            state <= next_state;
        end
    end

    // indications are pulses: cleared every cycle they are not raised
    always_ff @(posedge clk) begin
        if (srst) begin
            l2_activate_ind <= 1'b0;
            l2_deactivate_ind <= 1'b0;
            mgmt_activate_ind <= 1'b0;
            mgmt_error_ind <= 1'b0;
            mgmt_error_param <= `PRU_ERR_POWER;
        end else begin
            l2_activate_ind <= next_l2_act;
            l2_deactivate_ind <= next_l2_deact;
            mgmt_activate_ind <= next_mgmt_act;
            mgmt_error_ind <= next_mgmt_err;
            mgmt_error_param <= next_param;
        end
    end

    // ----------------------------------------
    // transmit side
    // ----------------------------------------

    // taken from next_state so it changes with state, not a cycle later
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_mode <= pru_tx_none;
            tx_timing_from_rx <= 1'b0;
        end else begin
            tx_mode <= tx_of(next_state);
            tx_timing_from_rx <= has_timing(next_state);
        end
    end

    // crc errors only reported where received timing is trusted
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_crc_err_report <= 1'b0;
        end else begin
            tx_crc_err_report <= rx.crc_err && has_timing(state);
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    err_param_range_a: assert property (
        mgmt_error_ind |-> mgmt_error_param <= `PRU_ERR_MAX)
        else $error("error parameter out of range");

    power_on_entry_a: assert property (
        state == state_power_off && power_return && !power_loss
        |=> state == state_power_on && !mgmt_error_ind)
        else $error("power return did not enter power-on");

    recovery_act_a: assert property (
        is_fault(state) && ev == pru_ev_normal
        |=> l2_activate_ind && mgmt_activate_ind &&
            state == state_operational)
        else $error("recovery without both activates");

    power_loss_err_a: assert property (
        state != state_power_off && power_loss
        |=> mgmt_error_ind && mgmt_error_param == `PRU_ERR_POWER &&
            state == state_power_off)
        else $error("power loss not reported");

    no_repeat_err_a: assert property (
        mgmt_error_ind |-> state != $past(state))
        else $error("error issued without state change");

    deact_source_a: assert property (
        l2_deactivate_ind |-> $past(state) == state_operational &&
            state != state_signal_lost && mgmt_error_ind)
        else $error("deactivate from wrong transition");

    tx_kind_a: assert property (
        ##1 (tx_mode == tx_of(state) &&
             tx_timing_from_rx == has_timing(state)))
        else $error("transmit kind does not match state");

    merged_near_a: assert property (
        state == state_near_fault && $past(state) != state_near_fault
        |-> !$past(cfg.ignore_crc_rai))
        else $error("near fault entered while merged");

    loss_priority_a: assert property (
        state != state_power_off && rx.loss && !power_loss &&
        !power_return |=> state == state_signal_lost)
        else $error("signal loss lost priority");

    far_default_a: assert property (
        state == state_operational && rx.rai && !rx.loss && !rx.ais &&
        !power_loss && !power_return && !cfg.rate_1544 &&
        cfg.option != `PRU_OPT_2 && cfg.option != `PRU_OPT_3
        |=> state == state_far_fault ##1 tx_mode == pru_tx_normal)
        else $error("rai did not give far fault");

    pulse_single_a: assert property (
        l2_activate_ind |=> !l2_activate_ind && !mgmt_activate_ind)
        else $error("activate longer than a cycle");

    crc_report_a: assert property (
        rx.crc_err && has_timing(state) |=> tx_crc_err_report)
        else $error("crc error not reported back");

    crc_quiet_a: assert property (
        !has_timing(state) |=> !tx_crc_err_report)
        else $error("crc report without network timing");

    fault_no_deact_a: assert property (
        is_fault(state) |=> !l2_deactivate_ind)
        else $error("deactivate between fault states");

    loss_no_deact_a: assert property (
        state == state_operational && ev == pru_ev_loss
        |=> state == state_signal_lost && !l2_deactivate_ind &&
            mgmt_error_param == `PRU_ERR_LOSS)
        else $error("signal loss from operational misreported");

    // ----------------------------------------
    // covers
    // ----------------------------------------

    op_to_far_c: cover property (
        state == state_operational ##1 state == state_far_fault);

    far_recover_c: cover property (
        state == state_far_fault ##1 state == state_operational);

    near_entry_c: cover property (
        state == state_operational ##1 state == state_near_fault);

    power_cycle_c: cover property (
        state == state_power_off ##1 state == state_power_on);

    alarm_recover_c: cover property (
        state == state_alarm_received ##1 state == state_operational);

endmodule

// file: design/pru_consts.svh
// constants for the primary rate user-side layer 1 state machine
// assumes inclusion by bare name from the design
`ifndef PRU_CONSTS_SVH
`define PRU_CONSTS_SVH

// error indication parameter values
`define PRU_ERR_POWER 3'h0
`define PRU_ERR_RAI 3'h1
`define PRU_ERR_LOSS 3'h2
`define PRU_ERR_AIS 3'h3
`define PRU_ERR_RAI_CRC 3'h4
`define PRU_ERR_MAX 3'h4

// network option codes
`define PRU_OPT_2 3'h2
`define PRU_OPT_3 3'h3

`endif

// file: design/pru_pkg.sv
// types for the primary rate user-side layer 1 state machine
// assumes pru_consts.svh sits beside it
package pru_pkg;

    // layer 1 states at the user side
    typedef enum logic [2:0] {
        state_power_off,
        state_operational,
        state_far_fault,
        state_signal_lost,
        state_alarm_received,
        state_near_fault,
        state_power_on
    } pru_state_e;

    // kind of signal sent toward the interface
    typedef enum logic [1:0] {
        pru_tx_none,
        pru_tx_normal,
        pru_tx_rai
    } pru_tx_e;

    // one event chosen per cycle
    typedef enum logic [2:0] {
        pru_ev_none,
        pru_ev_pwr_loss,
        pru_ev_pwr_ret,
        pru_ev_loss,
        pru_ev_ais,
        pru_ev_rai_crc,
        pru_ev_rai,
        pru_ev_normal
    } pru_ev_e;

    // received-line events, one-cycle pulses or levels from the framer
    typedef struct packed {
        logic loss;     // loss of signal or frame alignment
        logic ais;      // alarm indication signal seen
        logic rai;      // remote alarm seen
        logic crc_cont; // continuous crc error report with rai
        logic prm_exch; // 1544 perf report from exchange termination
        logic prm_user; // 1544 perf report from user side of nt
        logic normal;   // normal operational frames
        logic crc_err;  // crc check failed on a received frame
    } pru_rx_s;

    // static configuration
    typedef struct packed {
        logic rate_1544;      // 1 for 1544 kbit/s, 0 for 2048 kbit/s
        logic [2:0] option;   // network option number
        logic ignore_crc_rai; // merge far and near fault
    } pru_cfg_s;

endpackage

// file: test/pru_net_model.sv
// network-side model: turns a line condition into received-line events
// assumes the bench changes cmd and crc_bad just after a falling edge
module pru_net_model (
    input wire logic [2:0] cmd,   // condition the network presents
    input wire logic crc_bad,     // a received block fails its crc
    output pru_pkg::pru_rx_s rx   // events seen by the user side
);
    timeunit 1ns;
    timeprecision 1ps;
    import pru_pkg::*;

    // one condition per command; 0 is a silent line with no events
    // the framer view is decoded, so no wire level is modelled here
    always_comb begin
        rx = '0;
        rx.crc_err = crc_bad;
        case (cmd)
            3'h1: rx.normal = 1'b1;
            3'h2: rx.rai = 1'b1;
            3'h3: rx.loss = 1'b1;
            3'h4: rx.ais = 1'b1;
            3'h5: {rx.rai, rx.crc_cont, rx.prm_user} = 3'h7;
            3'h6: {rx.rai, rx.crc_cont, rx.prm_exch} = 3'h7;
            3'h7: {rx.loss, rx.ais, rx.rai} = 3'h7;
            default: ;
        endcase
    end
endmodule

// file: test/tb_top.sv
// self-checking bench for the user-side layer 1 state machine
// assumes the design files and pru_net_model are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pru_pkg::*;

    logic clk, srst, power_loss, power_return, crc_bad;
    logic [2:0] cmd;
    pru_rx_s rx;
    pru_cfg_s cfg;
    pru_state_e state;
    pru_state_e cur;
    pru_tx_e tx_mode;
    logic l2a, l2d, ma, me, tim, crep;
    logic [2:0] par;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    pru_net_model net (.cmd(cmd), .crc_bad(crc_bad), .rx(rx));
    pru_l1_fsm dut (.clk(clk), .srst(srst), .power_loss(power_loss),
        .power_return(power_return), .rx(rx), .cfg(cfg), .state(state),
        .l2_activate_ind(l2a), .l2_deactivate_ind(l2d), .mgmt_activate_ind(ma),
        .mgmt_error_ind(me), .mgmt_error_param(par), .tx_mode(tx_mode),
        .tx_timing_from_rx(tim), .tx_crc_err_report(crep));

    // ----
    // clock, watchdog and verdict
    // ----
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // a hung scenario still reaches the verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----
    // expectations and comparisons
    // ----
    function automatic pru_tx_e tx_of(pru_state_e s);
        case (s)
            state_power_off, state_power_on: return pru_tx_none;
            state_signal_lost, state_alarm_received: return pru_tx_rai;
            default: return pru_tx_normal;
        endcase
    endfunction

    // states where network timing is present
    function automatic logic timed(pru_state_e s);
        return s inside {state_operational, state_far_fault, state_near_fault};
    endfunction

    task automatic chk_state(pru_state_e exp);
        n_checks++;
        if (state !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: state %0d want %0d", $time, state, exp);
        end
    endtask

    task automatic chk_bits(logic [10:0] got, logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: outputs %h want %h", $time, got, exp);
        end
    endtask

    // ind is {l2 act, l2 deact, mgmt act, mgmt err, param}
    task automatic look(pru_state_e s, logic [6:0] ind, logic cr);
        logic [10:0] got;
        got = {l2a, l2d, ma, me, par, crep, tx_mode, tim};
        chk_state(s);
        chk_bits(got, {ind, cr, tx_of(s), timed(s)});
    endtask

    // event at a falling edge, answer one cycle on, then a quiet cycle
    // the line condition stays applied, as a real network keeps sending it
    task automatic step(logic pl, logic pr, logic [2:0] c, pru_state_e s, logic [6:0] ind);
        power_loss = pl;
        power_return = pr;
        cmd = c;
        @(negedge clk);
        look(s, ind, crc_bad && timed(cur));
        cur = s;
        power_loss = 1'b0;
        power_return = 1'b0;
        @(negedge clk);
        look(s, 7'h00, crc_bad && timed(s));
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset();
        look(state_power_off, 7'h00, 1'b0);
        step(1'b0, 1'b0, 3'h2, state_power_off, 7'h00);
        step(1'b0, 1'b0, 3'h3, state_power_off, 7'h00);
    endtask

    task automatic t_power();
        step(1'b0, 1'b1, 3'h0, state_power_on, 7'h00);
        step(1'b0, 1'b0, 3'h1, state_power_on, 7'h00);
        step(1'b0, 1'b1, 3'h1, state_power_on, 7'h00);
    endtask

    // fault to fault moves never deactivate layer 2
    task automatic t_chain();
        cfg = 5'h04;
        step(1'b0, 1'b0, 3'h2, state_far_fault, 7'h09);
        step(1'b0, 1'b0, 3'h4, state_alarm_received, 7'h0b);
        step(1'b0, 1'b0, 3'h5, state_near_fault, 7'h0c);
        step(1'b0, 1'b0, 3'h3, state_signal_lost, 7'h0a);
        step(1'b0, 1'b0, 3'h1, state_operational, 7'h50);
        step(1'b0, 1'b0, 3'h3, state_signal_lost, 7'h0a);
        step(1'b0, 1'b0, 3'h1, state_operational, 7'h50);
    endtask

    // remote alarm classification over rates, options and the merge option
    task automatic t_class();
        logic [4:0] cf [11] = '{5'h02, 5'h02, 5'h04, 5'h06, 5'h04, 5'h02,
            5'h05, 5'h14, 5'h14, 5'h12, 5'h18};
        logic [2:0] cm [11] = '{3'h2, 3'h4, 3'h5, 3'h5, 3'h2, 3'h5,
            3'h5, 3'h5, 3'h6, 3'h5, 3'h5};
        logic [2:0] pm [11] = '{3'h1, 3'h3, 3'h4, 3'h4, 3'h1, 3'h1,
            3'h1, 3'h4, 3'h1, 3'h1, 3'h1};
        pru_state_e st [11] = '{state_far_fault, state_alarm_received,
            state_near_fault, state_near_fault, state_far_fault, state_far_fault,
            state_far_fault, state_near_fault, state_far_fault, state_far_fault,
            state_far_fault};
        for (int i = 0; i < 11; i++) begin
            cfg = cf[i];
            step(1'b0, 1'b0, cm[i], st[i], {4'h5, pm[i]});
            step(1'b0, 1'b0, 3'h1, state_operational, 7'h50);
        end
    endtask

    // crc errors reported only while network timing is present
    task automatic t_crc();
        crc_bad = 1'b1;
        step(1'b0, 1'b0, 3'h1, state_operational, 7'h00);
        step(1'b0, 1'b0, 3'h3, state_signal_lost, 7'h0a);
        crc_bad = 1'b0;
        step(1'b0, 1'b0, 3'h1, state_operational, 7'h50);
    endtask

    // coinciding events resolved by fixed priority, power loss above all
    task automatic t_prio();
        step(1'b1, 1'b0, 3'h1, state_power_off, 7'h28);
        step(1'b0, 1'b1, 3'h0, state_power_on, 7'h00);
        step(1'b0, 1'b0, 3'h7, state_signal_lost, 7'h0a);
        step(1'b1, 1'b1, 3'h7, state_power_off, 7'h08);
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        srst = 1'b1;
        power_loss = 1'b0;
        power_return = 1'b0;
        crc_bad = 1'b0;
        cmd = 3'h0;
        cfg = 5'h02;
        cur = state_power_off;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_power();
        t_chain();
        t_class();
        t_crc();
        t_prio();
        final_report();
    end
endmodule
